/* cpu16_regfile_map.svh */
/*
 * Constants for the 16-bit CPU register file: register indices, flag word
 * bit positions, constant generator values, reset vector and step sizes.
 * Assumes inclusion by bare name from the design module and the testbench.
 */
`ifndef CPU16_REGFILE_MAP_SVH
`define CPU16_REGFILE_MAP_SVH

// Dedicated register indices
`define RIDX_IP        4'h0
`define RIDX_STK       4'h1
`define RIDX_FLAGS     4'h2
`define RIDX_CONST     4'h3

// Flag word bit positions
`define FB_CARRY       0
`define FB_ZERO        1
`define FB_NEG         2
`define FB_IRQEN       3
`define FB_HALT        4
`define FB_LFOSC       5
`define FB_LOOPOFF     6
`define FB_DCOFF       7
`define FB_OVF         8
`define FLAG_MASK      16'h01ff

// Constant generator values
`define CG_ZERO        16'h0000
`define CG_ONE         16'h0001
`define CG_TWO         16'h0002
`define CG_FOUR        16'h0004
`define CG_EIGHT       16'h0008
`define CG_ALLONES     16'hffff

// Reset vector word and stack step
`define RESET_VECTOR   16'hfffe
`define WORD_STEP      16'h0002
`define BYTE_STEP      16'h0001

`endif

/* cpu16_regfile_pkg.sv */
/*
 * Types for the 16-bit CPU register file: operand modes, ALU operation
 * classes, operand decode result and flag update bundle.
 * Assumes the map header sits in the same folder.
 */
`default_nettype none
package cpu16_regfile_pkg;

    // Operation classes that steer the overflow rule
    typedef enum logic [1:0] {
        op_add,
        op_sub,
        op_other
    } alu_class_t;

    // Decoded source operand location
    typedef enum logic [1:0] {
        loc_register,
        loc_indexed,
        loc_pointer,
        loc_constant
    } operand_loc_t;

    // Operand decode answer
    typedef struct packed {
        operand_loc_t loc;
        logic [15:0]  value;
        logic         autoinc;
        logic         extra_fetch;
    } operand_t;

    // Flag update request from the execution unit
    typedef struct packed {
        logic        valid;
        alu_class_t  cls;
        logic        byte_op;
        logic [15:0] op_a;
        logic [15:0] op_b;
        logic [16:0] raw_sum;
    } flag_req_t;

endpackage
`default_nettype wire

/* cpu16_regfile.sv */
/*
 * Register file and operand-mode logic of a 16-bit RISC CPU.
 * Assumes the execution unit drives one request per cycle, fetches offset
 * and immediate words itself, and sequences the reset vector load.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cpu16_regfile_map.svh"

module cpu16_regfile
    import cpu16_regfile_pkg::*;
#(
    parameter int NREGS = 16
)(
    // Clock and reset
    input  wire  logic        clk,
    input  wire  logic        srst,
    // Reset vector fetch answer
    input  wire  logic        vec_valid,
    input  wire  logic [15:0] vec_data,
    // Source operand decode
    input  wire  logic [3:0]  src_reg,
    input  wire  logic [1:0]  src_mode,
    input  wire  logic        src_byte,
    // Destination operand decode
    input  wire  logic [3:0]  dst_reg,
    input  wire  logic        dst_mode,
    // Result write port
    input  wire  logic        wr_en,
    input  wire  logic [3:0]  wr_reg,
    input  wire  logic [15:0] wr_data,
    input  wire  logic        wr_byte,
    // Sequencing strobes
    input  wire  logic        ip_step,
    input  wire  logic [1:0]  ip_words,
    input  wire  logic        push,
    input  wire  logic        pop,
    input  wire  logic        pop_to_stk,
    input  wire  logic [15:0] pop_data,
    input  wire  logic        autoinc_en,
    // Flag update request
    input  wire  flag_req_t   flag_req,
    // Clock source status
    input  wire  logic        lfxt_feeds_clk,
    input  wire  logic        fast_osc_feeds_clk,
    // Operand answers
    output var   operand_t    src_op,
    output var   logic [15:0] dst_addr_base,
    output var   logic        dst_is_reg,
    // Pointers and flags
    output var   logic [15:0] ip_out,
    output var   logic [15:0] stk_out,
    output var   logic [15:0] flags_out,
    output var   logic        reset_done,
    // Low-power and interrupt controls
    output var   logic        irq_enable,
    output var   logic        core_halt,
    output var   logic        lf_osc_stop,
    output var   logic        dc_gen_stop,
    output var   logic        fll_loop_off
);

    // Register array; entries 0 to 3 unused, registers 0 to 2 are held in their own flops and register 3 is the constant generator
    logic [15:0] regs_q [NREGS];
    logic [15:0] ip_q;
    logic [15:0] stk_q;
    logic [15:0] flags_q;
    logic        booted_q;
    operand_t    src_op_q;
    logic [15:0] dst_base_q;
    logic        dst_reg_q;
    logic [4:0]  ctl_q;

    // Byte results carry a cleared upper byte
    function automatic logic [15:0] fit(input logic [15:0] v, input logic b);
        fit = b ? {8'h00, v[7:0]} : v;
    endfunction

    // Current readable value of any register
    function automatic logic [15:0] rd(input logic [3:0] r);
        if (r == `RIDX_IP)
            rd = ip_q;
        else if (r == `RIDX_STK)
            rd = stk_q;
        else if (r == `RIDX_FLAGS)
            rd = flags_q;
        else if (r == `RIDX_CONST)
            rd = `CG_ZERO;
        else
            rd = regs_q[r];
    endfunction

    // Source constant generator decode
    wire         src_is_flagreg  = (src_reg == `RIDX_FLAGS);
    wire         src_is_constreg = (src_reg == `RIDX_CONST);
    wire         flagreg_const   = src_is_flagreg && (src_mode != 2'b00);
    wire [15:0]  flagreg_value   = (src_mode == 2'b01) ? `CG_ZERO :
                                   (src_mode == 2'b10) ? `CG_FOUR : `CG_EIGHT;
    wire [15:0]  constreg_value  = (src_mode == 2'b00) ? `CG_ZERO :
                                   (src_mode == 2'b01) ? `CG_ONE  :
                                   (src_mode == 2'b10) ? `CG_TWO  : `CG_ALLONES;
    wire         flagreg_abs     = src_is_flagreg && (src_mode == 2'b01);
    wire [15:0]  inc_step        = src_byte ? `BYTE_STEP : `WORD_STEP;

    // Source operand answer
    operand_t src_d;
    always_comb
    begin
        src_d = '0;
        if (src_is_constreg)
        begin
            src_d.loc   = loc_constant;
            src_d.value = constreg_value;
        end
        else if (flagreg_abs)
        begin
            src_d.loc         = loc_indexed;
            src_d.value       = flagreg_value;
            src_d.extra_fetch = 1'b1;
        end
        else if (flagreg_const)
        begin
            src_d.loc   = loc_constant;
            src_d.value = flagreg_value;
        end
        else if (src_mode == 2'b00)
        begin
            src_d.loc   = loc_register;
            src_d.value = src_is_flagreg ? flags_q : fit(rd(src_reg), src_byte);
        end
        else if (src_mode == 2'b01)
        begin
            src_d.loc         = loc_indexed;
            src_d.value       = rd(src_reg);
            src_d.extra_fetch = 1'b1;
        end
        else
        begin
            src_d.loc     = loc_pointer;
            src_d.value   = rd(src_reg);
            src_d.autoinc = (src_mode == 2'b11);
            src_d.extra_fetch = (src_mode == 2'b11) && (src_reg == `RIDX_IP);
        end
    end

    // Destination base: absolute via register 2 gives a zero base;
    // a process, since a continuous assign would miss register updates inside rd
    logic [15:0] dst_base_d;
    always_comb
    begin
        dst_base_d = rd(dst_reg);
        if (dst_reg == `RIDX_FLAGS && dst_mode)
            dst_base_d = `CG_ZERO;
    end
    wire        dst_reg_d  = !dst_mode;

    // Flag computation; byte ops look at bit 7 and the low byte
    wire [15:0] res      = flag_req.raw_sum[15:0];
    wire        sa       = flag_req.byte_op ? flag_req.op_a[7] : flag_req.op_a[15];
    wire        sb       = flag_req.byte_op ? flag_req.op_b[7] : flag_req.op_b[15];
    wire        res_neg  = flag_req.byte_op ? res[7] : res[15];
    wire        zr       = flag_req.byte_op ? (res[7:0] == 8'h00) : (res == 16'h0000);
    wire        cy       = flag_req.byte_op ? flag_req.raw_sum[8] : flag_req.raw_sum[16];
    wire        ov_add   = (sa == sb) && (res_neg != sa);
    wire        ov_sub   = (sa != sb) && (res_neg == sb);
    wire        ov       = (flag_req.cls == op_add) ? ov_add :
                           (flag_req.cls == op_sub) ? ov_sub : 1'b0;

    // Next instruction pointer; lengths of 2, 4 or 6 bytes only
    wire [15:0] ip_len  = {13'h0000, ip_words, 1'b0};
    wire        pop_stk  = pop && pop_to_stk;
    wire [15:0] stk_push = stk_q - `WORD_STEP;
    wire [15:0] stk_pop  = stk_q + `WORD_STEP;
    wire        wr_ok   = wr_en && (wr_reg != `RIDX_CONST);
    wire        wr_fl   = wr_ok && (wr_reg == `RIDX_FLAGS) && !wr_byte;
    wire        ai_go   = autoinc_en && src_op_q.autoinc;

    // Instruction pointer: reset vector, writes, autoincrement, step
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ip_q     <= 16'h0000;
            booted_q <= 1'b0;
        end
        else if (!booted_q)
        begin
            if (vec_valid)
            begin
                ip_q     <= {vec_data[15:1], 1'b0};
                booted_q <= 1'b1;
            end
        end
        else if (wr_ok && wr_reg == `RIDX_IP)
            ip_q <= {wr_data[15:1], 1'b0};
        else if (ip_step && ip_words != 2'b00)
            ip_q <= ip_q + ip_len;
        else if (ai_go && src_reg == `RIDX_IP)
            ip_q <= ip_q + `WORD_STEP;
    end

    // Stack pointer: push, pop, pop into itself, explicit write
    always_ff @(posedge clk)
    begin
        if (srst)
            stk_q <= 16'h0000;
        else if (pop_stk)
            stk_q <= {pop_data[15:1], 1'b0};
        else if (push)
            stk_q <= {stk_push[15:1], 1'b0};
        else if (pop)
            stk_q <= {stk_pop[15:1], 1'b0};
        else if (wr_ok && wr_reg == `RIDX_STK)
            stk_q <= {wr_data[15:1], 1'b0};
        else if (ai_go && src_reg == `RIDX_STK)
            stk_q <= stk_q + `WORD_STEP;
    end

    // Flag word: register writes beat arithmetic updates
    always_ff @(posedge clk)
    begin
        if (srst)
            flags_q <= 16'h0000;
        else if (wr_fl)
            flags_q <= wr_data & `FLAG_MASK;
        else if (flag_req.valid)
        begin
            flags_q[`FB_CARRY] <= cy;
            flags_q[`FB_ZERO]  <= zr;
            flags_q[`FB_NEG]   <= res_neg;
            flags_q[`FB_OVF]   <= ov;
        end
    end

    // General registers; autoincrement after the operand fetch
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < NREGS; i++)
                regs_q[i] <= 16'h0000;
        end
        else if (wr_ok && wr_reg > `RIDX_CONST)
            regs_q[wr_reg] <= fit(wr_data, wr_byte);
        else if (ai_go && src_reg > `RIDX_CONST)
            regs_q[src_reg] <= regs_q[src_reg] + inc_step;
    end

    // Registered operand answers and low-power controls
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            src_op_q   <= '0;
            dst_base_q <= 16'h0000;
            dst_reg_q  <= 1'b0;
            ctl_q      <= 5'h00;
        end
        else
        begin
            src_op_q   <= src_d;
            dst_base_q <= dst_base_d;
            dst_reg_q  <= dst_reg_d;
            ctl_q[0]   <= flags_q[`FB_IRQEN];
            ctl_q[1]   <= flags_q[`FB_HALT];
            ctl_q[2]   <= flags_q[`FB_LFOSC] && !lfxt_feeds_clk;
            ctl_q[3]   <= flags_q[`FB_DCOFF] && !fast_osc_feeds_clk;
            ctl_q[4]   <= flags_q[`FB_LOOPOFF];
        end
    end

    // Outputs straight from flip-flops
    assign src_op        = src_op_q;
    assign dst_addr_base = dst_base_q;
    assign dst_is_reg    = dst_reg_q;
    assign ip_out        = ip_q;
    assign stk_out       = stk_q;
    assign flags_out     = flags_q;
    assign reset_done    = booted_q;
    assign irq_enable    = ctl_q[0];
    assign core_halt     = ctl_q[1];
    assign lf_osc_stop   = ctl_q[2];
    assign dc_gen_stop   = ctl_q[3];
    assign fll_loop_off  = ctl_q[4];

    // Constant register 3 answers within one cycle
    sequence s_const_req;
        src_is_constreg && src_mode == 2'b11;
    endsequence
    property p_const_allones;
        @(posedge clk) disable iff (srst) s_const_req
            |=> src_op.value == `CG_ALLONES && src_op.loc == loc_constant;
    endproperty
    a_const_allones: assert property (p_const_allones) else $error("constant mode 11 not all-ones");

    property p_flagreg_four;
        @(posedge clk) disable iff (srst) (src_is_flagreg && src_mode == 2'b10) |=> src_op.value == `CG_FOUR;
    endproperty
    a_flagreg_four: assert property (p_flagreg_four) else $error("flag register mode 10 not four");

    property p_push_dec;
        @(posedge clk) disable iff (srst) (push && !pop) |=> stk_out == (($past(stk_out) - 16'h0002) & 16'hfffe);
    endproperty
    a_push_dec: assert property (p_push_dec) else $error("push did not decrement");

    property p_pop_stk;
        @(posedge clk) disable iff (srst) pop_stk |=> stk_out == {$past(pop_data[15:1]), 1'b0};
    endproperty
    a_pop_stk: assert property (p_pop_stk) else $error("pop into stack pointer wrong");

    property p_ptr_even;
        @(posedge clk) disable iff (srst) ##1 (stk_out[0] == 1'b0 && ip_out[0] == 1'b0);
    endproperty
    a_ptr_even: assert property (p_ptr_even) else $error("pointer bit 0 set");

    // Byte writes never reach the flag word
    property p_flag_byte_wr;
        @(posedge clk) disable iff (srst) (wr_en && wr_reg == `RIDX_FLAGS && wr_byte && !flag_req.valid)
            |=> flags_out == $past(flags_out);
    endproperty
    a_flag_byte_wr: assert property (p_flag_byte_wr) else $error("byte write changed flag word");

    property p_byte_wr_upper;
        @(posedge clk) disable iff (srst) (wr_en && wr_reg > `RIDX_CONST && wr_byte)
            |=> regs_q[$past(wr_reg)][15:8] == 8'h00;
    endproperty
    a_byte_wr_upper: assert property (p_byte_wr_upper) else $error("byte write kept upper byte");

    // Immediate fetch steps the instruction pointer past the data word
    property p_imm_skip;
        @(posedge clk) disable iff (srst)
            (booted_q && ai_go && src_reg == `RIDX_IP && !wr_ok && !ip_step)
            |=> ip_out == $past(ip_out) + `WORD_STEP;
    endproperty
    a_imm_skip: assert property (p_imm_skip) else $error("immediate did not skip its word");

    property p_ip_step;
        @(posedge clk) disable iff (srst) (booted_q && ip_step && ip_words == 2'b10 && !wr_en)
            |=> ip_out == $past(ip_out) + 16'h0004;
    endproperty
    a_ip_step: assert property (p_ip_step) else $error("ip did not advance by four");

    property p_zero_flag;
        @(posedge clk) disable iff (srst) (flag_req.valid && !wr_fl) |=> flags_out[`FB_ZERO] == $past(zr);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

    property p_halt;
        @(posedge clk) disable iff (srst) flags_q[`FB_HALT] |=> core_halt;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not driven");

endmodule // cpu16_regfile
`default_nettype wire

/* exec_mem_model.sv */
/*
 * Far-side model: the execution unit's reset vector fetch.
 * Assumes one clock and a synchronous active-high reset shared with the block.
 */
`timescale 1ns/10ps
`default_nettype none
module exec_mem_model
#(
    parameter logic [15:0] VECTOR_WORD  = 16'h4a37,
    parameter int          ANSWER_DELAY = 3
)(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Reset vector answer
    output var  logic        vec_valid,
    output var  logic [15:0] vec_data
);
    int   wait_q;
    logic sent_q;

    // One vector word per reset; a slow answer tests the wait in the block
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wait_q    <= 0;
            sent_q    <= 1'b0;
            vec_valid <= 1'b0;
            vec_data  <= ~VECTOR_WORD;
        end
        else if (!sent_q && wait_q == ANSWER_DELAY)
        begin
            vec_valid <= 1'b1;
            vec_data  <= VECTOR_WORD;
            sent_q    <= 1'b1;
        end
        else
        begin
            wait_q    <= wait_q + 1;
            vec_valid <= 1'b0;
            vec_data  <= vec_data ^ 16'h5a5a; // Undriven bus: never the old word
        end
    end
endmodule // exec_mem_model
`default_nettype wire

/* testbench.sv */
/*
 * Self-checking bench for the register file and operand decode.
 * Assumes the map header and package sit in this folder.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cpu16_regfile_map.svh"
module testbench
    import cpu16_regfile_pkg::*;
;
    localparam logic [15:0] VEC_WORD = 16'h4a37;
    logic        clk = 1'b0, srst = 1'b1, vec_valid;
    logic [15:0] vec_data, wr_data = '0, pop_data = '0;
    logic [3:0]  src_reg = '0, dst_reg = '0, wr_reg = '0;
    logic [1:0]  src_mode = '0, ip_words = '0;
    logic        src_byte = 1'b0, dst_mode = 1'b0, wr_en = 1'b0, wr_byte = 1'b0, ip_step = 1'b0;
    logic        push = 1'b0, pop = 1'b0, pop_to_stk = 1'b0, autoinc_en = 1'b0, lfxt_feeds_clk = 1'b0;
    logic        fast_osc_feeds_clk = 1'b0;
    flag_req_t   flag_req = '0;
    operand_t    src_op;
    logic [15:0] dst_addr_base, ip_out, stk_out, flags_out;
    logic        dst_is_reg, reset_done, irq_enable, core_halt, lf_osc_stop, dc_gen_stop, fll_loop_off;
    logic [15:0] gpr [16];
    int          errors = 0;
    int          num_checks = 0;

    always #12.5 clk = ~clk;

    cpu16_regfile u_cpu16_regfile (.clk(clk), .srst(srst), .vec_valid(vec_valid), .vec_data(vec_data),
        .src_reg(src_reg), .src_mode(src_mode), .src_byte(src_byte), .dst_reg(dst_reg), .dst_mode(dst_mode),
        .wr_en(wr_en), .wr_reg(wr_reg), .wr_data(wr_data), .wr_byte(wr_byte), .ip_step(ip_step),
        .ip_words(ip_words), .push(push), .pop(pop), .pop_to_stk(pop_to_stk), .pop_data(pop_data),
        .autoinc_en(autoinc_en), .flag_req(flag_req), .lfxt_feeds_clk(lfxt_feeds_clk),
        .fast_osc_feeds_clk(fast_osc_feeds_clk), .src_op(src_op), .dst_addr_base(dst_addr_base),
        .dst_is_reg(dst_is_reg), .ip_out(ip_out), .stk_out(stk_out), .flags_out(flags_out), .reset_done(reset_done),
        .irq_enable(irq_enable), .core_halt(core_halt), .lf_osc_stop(lf_osc_stop), .dc_gen_stop(dc_gen_stop),
        .fll_loop_off(fll_loop_off));

    exec_mem_model #(.VECTOR_WORD(VEC_WORD), .ANSWER_DELAY(3)) u_exec_mem_model (.clk(clk), .srst(srst),
        .vec_valid(vec_valid), .vec_data(vec_data));

    // Comparisons
    task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        check16({15'h0, got}, {15'h0, exp}, what);
    endtask

    task automatic give_verdict();
        $display("Checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Strobes last one cycle; results are sampled just after that edge
    task automatic finish_op();
        @(posedge clk);
        wr_en <= 1'b0;
        ip_step <= 1'b0;
        push <= 1'b0;
        pop <= 1'b0;
        pop_to_stk <= 1'b0;
        autoinc_en <= 1'b0;
        flag_req.valid <= 1'b0;
        #1;
    endtask

    task automatic write_reg(input logic [3:0] r, input logic [15:0] d, input logic b);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_reg <= r;
        wr_data <= d;
        wr_byte <= b;
        finish_op();
    endtask

    task automatic read_src(input logic [3:0] r, input logic [1:0] m, input logic b);
        @(posedge clk);
        src_reg <= r;
        src_mode <= m;
        src_byte <= b;
        dst_reg <= r;
        dst_mode <= m[0];
        finish_op();
    endtask

    // Expected carry, zero, negative and overflow bits
    function automatic logic [15:0] flag_exp(input logic [15:0] a, b, input logic [16:0] raw, input logic bt, sb);
        logic [15:0] r;
        logic        sa, so, rn;
        r = bt ? {8'h00, raw[7:0]} : raw[15:0];
        sa = bt ? a[7] : a[15];
        so = bt ? b[7] : b[15];
        rn = bt ? r[7] : r[15];
        return {7'h0, sb ? (sa != so && rn != sa) : (sa == so && rn != sa), 5'h0, rn, r == 16'h0,
            bt ? raw[8] : raw[16]};
    endfunction

    // Watchdog against a hung run
    initial
    begin
        #2500000;
        errors++;
        give_verdict();
    end

    initial
    begin
        int          i;
        logic [15:0] a, b, d, exp_ip, exp_flags;
        logic [16:0] raw;
        logic        bt, sb;
        logic [15:0] cg_tab [8];
        void'($urandom(56));
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        #1;
        check16(ip_out | stk_out | flags_out, 16'h0000, "reset values");
        // Look just after each edge, never in the step that launches the flag
        for (i = 0; i < 20 && reset_done !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        check_bit(reset_done, 1'b1, "vector load done");
        exp_ip = VEC_WORD & 16'hfffe;
        check16(ip_out, exp_ip, "ip from vector");
        // Instruction lengths of 0 (ignored), one, two and three words
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk);
            ip_step <= 1'b1;
            ip_words <= 2'(i);
            finish_op();
            exp_ip += 16'(2 * i);
            check16(ip_out, exp_ip, "ip step");
        end
        write_reg(4'h0, 16'h1235, 1'b0);
        exp_ip = 16'h1234;
        check16(ip_out, exp_ip, "ip aligned");
        write_reg(4'h1, 16'h0a01, 1'b0);
        check16(stk_out, 16'h0a00, "stack aligned");
        @(posedge clk);
        push <= 1'b1;
        finish_op();
        check16(stk_out, 16'h09fe, "push");
        @(posedge clk);
        pop <= 1'b1;
        finish_op();
        check16(stk_out, 16'h0a00, "pop");
        @(posedge clk);
        pop <= 1'b1;
        pop_to_stk <= 1'b1;
        pop_data <= 16'h0c44;
        finish_op();
        check16(stk_out, 16'h0c44, "pop into stack pointer");
        // General registers: word and byte writes, then register, indexed and autoincrement modes
        for (i = 4; i < 16; i++)
        begin
            {d, bt} = {16'($urandom), 1'($urandom)};
            write_reg(4'(i), d, bt);
            gpr[i] = bt ? {8'h00, d[7:0]} : d;
        end
        for (i = 4; i < 16; i++)
        begin
            bt = 1'($urandom);
            read_src(4'(i), 2'b00, 1'b0);
            check16(src_op.value, gpr[i], "register mode");
            check_bit(dst_is_reg, 1'b1, "dst register");
            read_src(4'(i), 2'b01, 1'b0);
            check16({13'h0, src_op.loc, src_op.extra_fetch}, {13'h0, loc_indexed, 1'b1}, "indexed");
            check16(dst_addr_base, gpr[i], "dst base");
            read_src(4'(i), 2'b11, bt);
            check16({13'h0, src_op.loc, src_op.autoinc}, {13'h0, loc_pointer, 1'b1}, "pointer");
            @(posedge clk);
            autoinc_en <= 1'b1;
            finish_op();
            read_src(4'(i), 2'b00, 1'b0);
            check16(src_op.value, gpr[i] + (bt ? 16'h1 : 16'h2), "autoincrement");
        end
        // Flag updates, random with overflow corners first
        for (i = 0; i < 40; i++)
        begin
            {a, b, bt, sb} = {16'($urandom), 16'($urandom), 2'($urandom)};
            if (i < 2)
                {a, b, bt, sb} = (i == 0) ? {16'h7fff, 16'h0001, 2'b00} : {16'h0080, 16'h0001, 2'b11};
            raw = sb ? {1'b0, a} + {1'b0, ~b} + 17'h1 : {1'b0, a} + {1'b0, b};
            if (bt)
                raw = sb ? {9'h0, a[7:0]} + {9'h0, ~b[7:0]} + 17'h1 : {9'h0, a[7:0]} + {9'h0, b[7:0]};
            @(posedge clk);
            flag_req <= '{1'b1, sb ? op_sub : op_add, bt, a, b, raw};
            finish_op();
            check16(flags_out & 16'h0107, flag_exp(a, b, raw, bt, sb), "flags");
        end
        // Control bits against each clock source state
        for (i = 0; i < 4; i++)
        begin
            d = (i == 3) ? 16'($urandom) & 16'hff07 : 16'($urandom) | 16'h00f8;
            @(posedge clk);
            lfxt_feeds_clk <= i[0];
            fast_osc_feeds_clk <= i[1];
            write_reg(4'h2, d, 1'b0);
            exp_flags = d & `FLAG_MASK;
            write_reg(4'h2, ~d, 1'b1);
            check16(flags_out, exp_flags, "flag word write");
            check_bit(irq_enable, d[3], "irq enable");
            check_bit(core_halt, d[4], "core halt");
            check_bit(lf_osc_stop, d[5] & ~i[0], "osc stop");
            check_bit(dc_gen_stop, d[7] & ~i[1], "dc gen stop");
            check_bit(fll_loop_off, d[6], "loop off");
        end
        // Constant generators; register 3 ignores writes
        write_reg(4'h3, 16'h1234, 1'b0);
        cg_tab = '{exp_flags, 16'h0, `CG_FOUR, `CG_EIGHT, `CG_ZERO, `CG_ONE, `CG_TWO, `CG_ALLONES};
        for (i = 0; i < 8; i++)
        begin
            read_src((i < 4) ? 4'h2 : 4'h3, 2'(i), 1'b0);
            check16(src_op.value, cg_tab[i], "constant value");
            if (i > 1)
                check16({13'h0, src_op.loc, src_op.extra_fetch}, {13'h0, loc_constant, 1'b0}, "constant");
        end
        read_src(4'h0, 2'b01, 1'b0);
        check16(src_op.value, exp_ip, "symbolic base");
        read_src(4'h0, 2'b11, 1'b0);
        check16({13'h0, src_op.loc, src_op.extra_fetch}, {13'h0, loc_pointer, 1'b1}, "immediate fetch");
        @(posedge clk);
        autoinc_en <= 1'b1;
        finish_op();
        check16(ip_out, exp_ip + 16'h2, "immediate");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
